/* src/flash_command_sequencer.sv */
// Command sequencer of the embedded flash controller
`timescale 1ns/1ps
module flash_command_sequencer
  import flash_seq_pkg::*;
#(
  parameter logic SECOND_INSTANCE = 1'b0  // Second controller: no general or security bits
) (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // Command register write and status read
  input  wire logic                 cmd_write,
  input  wire logic [31:0]          cmd_data,
  input  wire logic                 status_read,
  // Mode register bits
  input  wire logic                 no_erase_before_program,
  input  wire logic                 ready_irq_enable,
  input  wire logic                 lock_error_irq_enable,
  input  wire logic                 prog_error_irq_enable,
  // Latch buffer writes
  input  wire logic                 latch_write,
  input  wire logic [7:0]           latch_addr,
  input  wire logic [31:0]          latch_data,
  // External hardware erase request
  input  wire logic                 hw_erase_req,
  // Flash cell array
  input  wire logic                 cell_done,
  output logic                      cell_req,
  output cell_op_type               cell_op,
  output logic      [PAGE_W-1:0]    cell_page,
  output logic                      cell_wvalid,
  output logic      [WIDX_W-1:0]    cell_widx,
  output logic      [31:0]          cell_wdata,
  output logic                      flash_read_enable,
  // Status
  output logic                      flash_ready_flag,
  output logic                      program_error_flag,
  output logic                      lock_error_flag,
  output logic      [LOCK_BITS-1:0] region_lock_status,
  output logic      [GP_BITS-1:0]   general_bit_status,
  output logic                      security_status,
  output logic                      debug_access_block,
  output logic                      flash_irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  seq_state_type           state;         // Sequencer state
  logic [CMD_W-1:0]        cmd_code;      // Command being executed
  logic [PAGE_W-1:0]       cmd_page;      // Page or bit number of command
  logic                    hw_wipe;       // Hardware erase in progress
  logic [WIDX_W-1:0]       load_idx;      // Latch word being streamed out
  logic [CMD_W-1:0]        code_in;       // Code field of the written word
  logic [PAGE_W-1:0]       page_in;       // Page field of the written word
  logic                    key_good;      // Key field matches
  logic                    take_write;    // Command write seen while idle
  logic                    take_hw;       // Hardware erase accepted
  logic                    go_cmd;        // Valid command accepted
  logic                    bad_cmd;       // Bad key or unlisted code
  logic                    lock_err_set;  // Command refused by a lock
  logic                    page_locked;   // Target region locked
  logic                    any_locked;    // Some region locked
  logic                    is_page_cmd;   // Write page or write-and-lock
  nv_bits_if               nv ();         // Link to the bit store

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  assign code_in   = cmd_data[CMD_W-1:0];
  assign page_in   = cmd_data[PAGE_LSB +: PAGE_W];
  assign key_good  = (cmd_data[KEY_LSB +: 8] == KEY_VALUE);
  // Writes during a running command are dropped; hardware erase wins a tie
  assign take_write = cmd_write && (state == S_IDLE) && !hw_erase_req;
  assign take_hw    = hw_erase_req && (state == S_IDLE);
  assign go_cmd     = take_write && key_good && cmd_is_listed(code_in);
  // Code zero with a good key is silently accepted and does nothing
  assign bad_cmd    = take_write && (!key_good ||
                      (!cmd_is_listed(code_in) && code_in != CMD_NONE));
  assign is_page_cmd = (code_in == CMD_WRITE_PAGE) || (code_in == CMD_WRITE_LOCK);
  assign page_locked = !nv.lock_stored[region_of(page_in)];
  assign any_locked  = (nv.lock_stored != LOCK_STORED_RESET);
  assign lock_err_set = go_cmd && ((is_page_cmd && page_locked) ||
                        (code_in == CMD_ERASE_ALL && any_locked));

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state machine
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: begin
          if (take_hw) begin
            state <= S_PLANE;
          end else if (lock_err_set) begin
            state <= S_FINISH;
          end else if (go_cmd) begin
            case (code_in)
              CMD_WRITE_PAGE, CMD_WRITE_LOCK: begin
                state <= no_erase_before_program ? S_LOAD : S_ERASE;
              end
              CMD_ERASE_ALL: state <= S_PLANE;
              default:       state <= S_NV;
            endcase
          end
        end
        S_ERASE: begin
          if (cell_done) state <= S_LOAD;
        end
        S_LOAD: begin
          if (load_idx == LAST_WORD) state <= S_PROG;
        end
        S_PROG: begin
          if (cell_done) state <= (cmd_code == CMD_WRITE_LOCK) ? S_NV : S_FINISH;
        end
        S_PLANE: begin
          if (cell_done) state <= hw_wipe ? S_NV : S_FINISH;
        end
        S_NV: begin
          if (cell_done) state <= S_FINISH;
        end
        S_FINISH: state <= S_IDLE;
        default:  state <= S_IDLE;
      endcase
    end
  end

  // Command capture; the code is kept to steer later states
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmd_code <= CMD_NONE;
      cmd_page <= '0;
    end else if (go_cmd) begin
      cmd_code <= code_in;
      cmd_page <= page_in;
    end
  end

  // Hardware erase marker, held through the plane erase and the wipe
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hw_wipe <= 1'b0;
    end else if (take_hw) begin
      hw_wipe <= 1'b1;
    end else if (state == S_FINISH) begin
      hw_wipe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latch buffer and programming stream
  // Only the word index of the address is kept, so the page repeats
  page_latch_buffer u_latch (
    .core_clk (core_clk),
    .reset    (reset),
    .wr_en    (latch_write),
    .wr_idx   (latch_addr[WIDX_LSB +: WIDX_W]),
    .wr_data  (latch_data),
    .rd_idx   (load_idx),
    .rd_data  (cell_wdata)
  );

  // Word counter walks the whole page once per program
  always_ff @(posedge core_clk) begin
    if (reset) begin
      load_idx <= '0;
    end else if (state == S_LOAD) begin
      load_idx <= load_idx + 1'b1;
    end else begin
      load_idx <= '0;
    end
  end

  // Valid and index are registered in the same cycle as the read, so they line up with its data
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cell_wvalid <= 1'b0;
      cell_widx   <= '0;
    end else begin
      cell_wvalid <= (state == S_LOAD);
      cell_widx   <= load_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cell array requests
  always_comb begin
    case (state)
      S_ERASE: cell_op = CELL_ERASE_PAGE;
      S_PROG:  cell_op = CELL_PROGRAM_PAGE;
      S_PLANE: cell_op = CELL_ERASE_PLANE;
      S_NV:    cell_op = CELL_NV_WRITE;
      default: cell_op = CELL_IDLE;
    endcase
  end
  assign cell_req  = (cell_op != CELL_IDLE);
  assign cell_page = cmd_page;
  // Array busy only for page and plane work; bit writes leave reads open
  assign flash_read_enable = (state == S_IDLE) || (state == S_NV) ||
                             (state == S_FINISH);

  ////////////////////////////////////////////////////////////////////////////
  // Non-volatile bit store
  always_comb begin
    if (hw_wipe) begin
      nv.op = NV_WIPE;
    end else begin
      case (cmd_code)
        CMD_SET_LOCK, CMD_WRITE_LOCK: nv.op = NV_SET_LOCK;
        CMD_CLEAR_LOCK:               nv.op = NV_CLEAR_LOCK;
        CMD_SET_GP:                   nv.op = NV_SET_GP;
        CMD_CLEAR_GP:                 nv.op = NV_CLEAR_GP;
        default:                      nv.op = NV_SET_SEC;
      endcase
    end
  end
  assign nv.strobe = (state == S_NV) && cell_done;
  assign nv.index  = cmd_page;

  nv_bit_store #(
    .HAS_GP_SEC (!SECOND_INSTANCE)
  ) u_nv (
    .core_clk (core_clk),
    .reset    (reset),
    .nv       (nv)
  );

  // Status view: stored zero reads as an active lock or general bit
  assign region_lock_status = ~nv.lock_stored;
  assign general_bit_status = ~nv.gp_stored;
  assign security_status    = nv.sec_active;
  assign debug_access_block = nv.sec_active;

  ////////////////////////////////////////////////////////////////////////////
  // Status flags
  // Ready drops on acceptance and rises as the command finishes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flash_ready_flag <= 1'b1;
    end else if (state == S_FINISH) begin
      flash_ready_flag <= 1'b1;
    end else if (go_cmd || take_hw) begin
      flash_ready_flag <= 1'b0;
    end
  end

  // Error flags: a new error wins over a read in the same cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      program_error_flag <= 1'b0;
    end else if (bad_cmd) begin
      program_error_flag <= 1'b1;
    end else if (status_read) begin
      program_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      lock_error_flag <= 1'b0;
    end else if (lock_err_set) begin
      lock_error_flag <= 1'b1;
    end else if (status_read) begin
      lock_error_flag <= 1'b0;
    end
  end

  // Level interrupt: each flag flop gated by its enable input
  assign flash_irq = (flash_ready_flag && ready_irq_enable) ||
                     (lock_error_flag && lock_error_irq_enable) ||
                     (program_error_flag && prog_error_irq_enable);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  ready_drop_a: assert property (@(posedge core_clk) disable iff (reset)
    go_cmd |=> !flash_ready_flag)
    else $error("ready not cleared on command");

  bad_key_a: assert property (@(posedge core_clk) disable iff (reset)
    take_write && !key_good |=> program_error_flag && state == S_IDLE)
    else $error("bad key not flagged");

  noop_code_a: assert property (@(posedge core_clk) disable iff (reset)
    take_write && key_good && code_in == CMD_NONE && !program_error_flag
      |=> !program_error_flag && state == S_IDLE)
    else $error("empty command had an effect");

  busy_ignore_a: assert property (@(posedge core_clk) disable iff (reset)
    cmd_write && state != S_IDLE && !program_error_flag |=> !program_error_flag)
    else $error("busy write was acted on");

  locked_page_a: assert property (@(posedge core_clk) disable iff (reset)
    go_cmd && is_page_cmd && page_locked
      |=> lock_error_flag && !cell_req ##1 state == S_IDLE)
    else $error("locked page was programmed");

  erase_refuse_a: assert property (@(posedge core_clk) disable iff (reset)
    go_cmd && code_in == CMD_ERASE_ALL && any_locked |=> lock_error_flag && !cell_req)
    else $error("erase all ran with a lock set");

  no_erase_a: assert property (@(posedge core_clk) disable iff (reset)
    go_cmd && is_page_cmd && !page_locked
      |=> (state == S_ERASE) == !$past(no_erase_before_program))
    else $error("erase choice wrong");

  ready_irq_a: assert property (@(posedge core_clk) disable iff (reset)
    state == S_FINISH && ready_irq_enable |=> flash_ready_flag && flash_irq)
    else $error("ready interrupt missing");

  lock_irq_a: assert property (@(posedge core_clk) disable iff (reset)
    lock_err_set && lock_error_irq_enable |=> flash_irq)
    else $error("lock error interrupt missing");

  write_lock_a: assert property (@(posedge core_clk) disable iff (reset)
    state == S_PROG && cell_done && cmd_code == CMD_WRITE_LOCK
      |=> state == S_NV && nv.op == NV_SET_LOCK)
    else $error("write-and-lock skipped locking");

  // Taken from the request code, so a slip in the state decode shows here
  read_open_a: assert property (@(posedge core_clk) disable iff (reset)
    cell_op == CELL_NV_WRITE |-> flash_read_enable)
    else $error("reads blocked during bit write");

  // Bit store results, seen one edge after the strobe
  lock_view_a: assert property (@(posedge core_clk) disable iff (reset)
    nv.strobe && nv.op == NV_SET_LOCK |=> region_lock_status[region_of(cmd_page)])
    else $error("lock status not raised");

  unlock_view_a: assert property (@(posedge core_clk) disable iff (reset)
    nv.strobe && nv.op == NV_CLEAR_LOCK |=> !region_lock_status[region_of(cmd_page)])
    else $error("lock status not cleared");

  sec_view_a: assert property (@(posedge core_clk) disable iff (reset)
    nv.strobe && nv.op == NV_SET_SEC && !SECOND_INSTANCE |=> security_status)
    else $error("security status not raised");

  // A status read with no new error in the same cycle empties both flags
  err_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    status_read && !bad_cmd && !lock_err_set |=> !program_error_flag && !lock_error_flag)
    else $error("error flags survived a status read");

  page_done_c: cover property (@(posedge core_clk) disable iff (reset)
    state == S_PROG && cell_done ##1 state == S_FINISH);
  write_lock_done_c: cover property (@(posedge core_clk) disable iff (reset)
    state == S_NV && cmd_code == CMD_WRITE_LOCK && cell_done);
  busy_write_c: cover property (@(posedge core_clk) disable iff (reset)
    cmd_write && state != S_IDLE);
  hw_wipe_c: cover property (@(posedge core_clk) disable iff (reset)
    nv.strobe && nv.op == NV_WIPE);
  refused_c: cover property (@(posedge core_clk) disable iff (reset) lock_err_set);
endmodule : flash_command_sequencer

/* src/flash_seq_pkg.sv */
// Constants, types and helper functions of the flash command sequencer
// Function
// - Auto-erase target page unless erase is disabled
// - Erase disabled: program only, allowing partial fills
// - One-page write latch, addressed modulo page size
// - Command write starts work and drops ready
// - Completion raises ready; interrupt if enabled
// - Bad key or code: program error, no effect
// - Page write into locked region: lock error
// - Write-and-lock locks region after programming
// - Erase-all refused if any region locked
// - Lock error interrupts when its enable set
// - Unlock stores one, lock stores zero
// - Reads continue during lock and general-bit commands
// - General bit number out of range: no change
// - Clear stores one, set stores zero
// - Security bit blocks external debug access
// - Hardware erase wipes plane, then bits and security in one write
// - Security status reflects bit; ready on completion
// - Second instance has no general or security bits
// - Fixed command code table
// - Code zero: nothing, no error; others error
// - Error flags clear on status read
package flash_seq_pkg;
  localparam logic [7:0] KEY_VALUE = 8'h5A;   // Command protection key
  localparam int KEY_LSB      = 24;            // Key field position
  localparam int PAGE_LSB     = 8;             // Page number field position
  localparam int PAGE_W       = 10;            // Page number width
  localparam int CMD_W        = 4;             // Command code width
  localparam int PAGE_WORDS   = 64;            // Words in one 256-byte page
  localparam int WIDX_W       = 6;             // Word index width
  localparam int WIDX_LSB     = 2;             // Byte address bit of word index
  localparam int LOCK_BITS    = 32;            // Lock regions
  localparam int REGION_SHIFT = 5;             // Pages per region is 32
  localparam int GP_BITS      = 3;             // General-purpose bits
  localparam logic [WIDX_W-1:0] LAST_WORD = 6'h3F;
  localparam logic [CMD_W-1:0] CMD_NONE        = 4'h0;
  localparam logic [CMD_W-1:0] CMD_WRITE_PAGE  = 4'h1;
  localparam logic [CMD_W-1:0] CMD_SET_LOCK    = 4'h2;
  localparam logic [CMD_W-1:0] CMD_WRITE_LOCK  = 4'h3;
  localparam logic [CMD_W-1:0] CMD_CLEAR_LOCK  = 4'h4;
  localparam logic [CMD_W-1:0] CMD_ERASE_ALL   = 4'h8;
  localparam logic [CMD_W-1:0] CMD_SET_GP      = 4'hB;
  localparam logic [CMD_W-1:0] CMD_CLEAR_GP    = 4'hD;
  localparam logic [CMD_W-1:0] CMD_SET_SEC     = 4'hF;
  localparam logic [LOCK_BITS-1:0] LOCK_STORED_RESET = 32'hFFFFFFFF;
  localparam logic [GP_BITS-1:0]   GP_STORED_RESET   = 3'h7;

  // Sequencer states, Gray along erase, load, program, nv, finish
  typedef enum logic [2:0] {
    S_IDLE   = 3'h0,
    S_ERASE  = 3'h1,
    S_LOAD   = 3'h3,
    S_PROG   = 3'h2,
    S_NV     = 3'h6,
    S_FINISH = 3'h4,
    S_PLANE  = 3'h7
  } seq_state_type;

  // Operation requested from the flash cell array
  typedef enum logic [2:0] {
    CELL_IDLE, CELL_ERASE_PAGE, CELL_PROGRAM_PAGE, CELL_ERASE_PLANE, CELL_NV_WRITE
  } cell_op_type;

  // Non-volatile bit operations
  typedef enum logic [2:0] {
    NV_SET_LOCK, NV_CLEAR_LOCK, NV_SET_GP, NV_CLEAR_GP, NV_SET_SEC, NV_WIPE
  } nv_op_type;

  // Listed command codes other than the empty one
  function automatic logic cmd_is_listed(input logic [CMD_W-1:0] code);
    case (code)
      CMD_WRITE_PAGE, CMD_SET_LOCK, CMD_WRITE_LOCK, CMD_CLEAR_LOCK,
      CMD_ERASE_ALL, CMD_SET_GP, CMD_CLEAR_GP, CMD_SET_SEC: cmd_is_listed = 1'b1;
      default: cmd_is_listed = 1'b0;
    endcase
  endfunction : cmd_is_listed

  // Lock region that holds a page
  function automatic logic [4:0] region_of(input logic [PAGE_W-1:0] page);
    region_of = page[PAGE_W-1:REGION_SHIFT];
  endfunction : region_of
endpackage : flash_seq_pkg

/* src/nv_bits_if.sv */
// Interface between the sequencer and its non-volatile bit store
`timescale 1ns/1ps
interface nv_bits_if;
  import flash_seq_pkg::*;
  logic                                strobe;       // One-cycle update pulse
  nv_op_type                           op;           // Operation to apply
  logic [PAGE_W-1:0]                   index;        // Page or bit number
  logic [LOCK_BITS-1:0]                lock_stored;  // Stored lock bits, 0 = locked
  logic [GP_BITS-1:0]                  gp_stored;    // Stored general bits, 0 = set
  logic                                sec_active;   // Security bit in force
  modport ctrl  (output strobe, op, index, input lock_stored, gp_stored, sec_active);
  modport store (input strobe, op, index, output lock_stored, gp_stored, sec_active);
endinterface : nv_bits_if

/* src/page_latch_buffer.sv */
// One-page write latch with registered read port
`timescale 1ns/1ps
module page_latch_buffer
  import flash_seq_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              wr_en,
  input  wire logic [WIDX_W-1:0] wr_idx,
  input  wire logic [31:0]       wr_data,
  input  wire logic [WIDX_W-1:0] rd_idx,
  output logic      [31:0]       rd_data
);
  logic [31:0] words [PAGE_WORDS];  // Latch storage, no reset needed

  ////////////////////////////////////////////////////////////////////////////
  // Word writes; only the word index is kept so the page repeats
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      words[wr_idx] <= wr_data;
    end
  end

  // Registered read feeding the programming stream
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= words[rd_idx];
    end
  end
endmodule : page_latch_buffer

/* src/nv_bit_store.sv */
// Lock, general-purpose and security bit store
`timescale 1ns/1ps
module nv_bit_store
  import flash_seq_pkg::*;
#(
  parameter logic HAS_GP_SEC = 1'b1  // Clear for the second controller instance
) (
  input  wire logic core_clk,
  input  wire logic reset,
  nv_bits_if.store  nv
);
  logic gp_in_range;  // Bit number names an implemented bit
  assign gp_in_range = (nv.index < PAGE_W'(GP_BITS));

  ////////////////////////////////////////////////////////////////////////////
  // Lock bits: erased state is unlocked
  always_ff @(posedge core_clk) begin
    if (reset) begin
      nv.lock_stored <= LOCK_STORED_RESET;
    end else if (nv.strobe) begin
      case (nv.op)
        NV_SET_LOCK:   nv.lock_stored[region_of(nv.index)] <= 1'b0;
        NV_CLEAR_LOCK: nv.lock_stored[region_of(nv.index)] <= 1'b1;
        NV_WIPE:       nv.lock_stored <= LOCK_STORED_RESET;
        default: ;
      endcase
    end
  end

  // General bits: absent on the second instance, range checked
  always_ff @(posedge core_clk) begin
    if (reset) begin
      nv.gp_stored <= GP_STORED_RESET;
    end else if (nv.strobe && HAS_GP_SEC) begin
      case (nv.op)
        NV_SET_GP:   if (gp_in_range) nv.gp_stored[nv.index[1:0]] <= 1'b0;
        NV_CLEAR_GP: if (gp_in_range) nv.gp_stored[nv.index[1:0]] <= 1'b1;
        NV_WIPE:     nv.gp_stored <= GP_STORED_RESET;
        default: ;
      endcase
    end
  end

  // Security bit: cleared by reset and by the wipe that follows a plane erase
  always_ff @(posedge core_clk) begin
    if (reset) begin
      nv.sec_active <= 1'b0;
    end else if (nv.strobe && HAS_GP_SEC) begin
      if (nv.op == NV_SET_SEC) begin
        nv.sec_active <= 1'b1;
      end else if (nv.op == NV_WIPE) begin
        nv.sec_active <= 1'b0;
      end
    end
  end

  gp_range_a: assert property (@(posedge core_clk) disable iff (reset)
    nv.strobe && (nv.op == NV_SET_GP || nv.op == NV_CLEAR_GP) && !gp_in_range
      |=> $stable(nv.gp_stored))
    else $error("out-of-range general bit changed");
  sec_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    nv.sec_active && !(nv.strobe && nv.op == NV_WIPE) |=> nv.sec_active)
    else $error("security bit cleared without wipe");
endmodule : nv_bit_store

/* bench/testbench.sv */
// Self-checking bench of the flash command sequencer
`timescale 1ns/1ps
module testbench;
  import flash_seq_pkg::*;
  logic core_clk, reset, cmd_write, status_read, no_erase, rie, lie, pie, latch_write;
  logic hw_erase_req, cell_done, c_req, c_wv, rdy, pe, le, sec, dbg, irq, rd_en;
  logic [31:0] cmd_data, latch_data, c_wd, lfsr_s, locks, m_lock;
  logic [31:0] lat [64];          // Copy of the page latch
  logic [7:0]  latch_addr;
  logic [9:0]  c_pg, pg_q;        // Page shown to the array, page expected there
  logic [5:0]  c_wi;
  logic [2:0]  gp, m_gp;
  logic        m_sec, m_le, m_pe, er_seen, rdy_q, pe_q;
  cell_op_type c_op;
  logic [40:0] nq [$];            // Expected status at each completion
  logic [31:0] wq [$];            // Expected words toward the array
  int          n_mismatch, compares;

  flash_command_sequencer u_flash_command_sequencer (.core_clk, .reset, .cmd_write,
    .cmd_data, .status_read, .no_erase_before_program(no_erase), .ready_irq_enable(rie),
    .lock_error_irq_enable(lie), .prog_error_irq_enable(pie), .latch_write, .latch_addr,
    .latch_data, .hw_erase_req, .cell_done, .cell_req(c_req), .cell_op(c_op), .cell_page(c_pg),
    .cell_wvalid(c_wv), .cell_widx(c_wi), .cell_wdata(c_wd), .flash_read_enable(rd_en),
    .flash_ready_flag(rdy), .program_error_flag(pe), .lock_error_flag(le),
    .region_lock_status(locks), .general_bit_status(gp), .security_status(sec),
    .debug_access_block(dbg), .flash_irq(irq));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  task automatic cmp(input logic [40:0] e, input logic [40:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp

  task automatic give_verdict;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // Bounded wait for a ready level, looked at where it is settled
  task automatic wait_rdy(input logic lvl);
    for (int i = 0; i < 400 && rdy !== lvl; i++) @(negedge core_clk);
  endtask : wait_rdy

  // Fill the latch top word first, so a wrong index shows in the data
  task automatic fill;
    for (int i = 63; i >= 0; i--) begin
      lfsr_s = nxt(lfsr_s);
      lat[i] = lfsr_s;
      @(posedge core_clk);
      latch_write <= 1'b1;
      latch_addr <= {i[5:0], 2'b00};
      latch_data <= lfsr_s;
    end
    @(posedge core_clk);
    latch_write <= 1'b0;
  endtask : fill

  // One command; the model notes the status expected when it completes
  task automatic run(input logic [7:0] key, input logic [3:0] code, input logic [9:0] pg,
                     input logic busy);
    logic ok, lk, er;
    lfsr_s = nxt(lfsr_s);
    lk = m_lock[pg[9:5]];
    ok = key == KEY_VALUE && code inside {1, 2, 3, 4, 8, 11, 13, 15};
    er = ok && code inside {1, 3} && !lk && !lfsr_s[3];
    if (ok) pg_q = pg;
    if (!ok) m_pe = code != 0 || key != KEY_VALUE;
    else case (code)
      1, 3: if (lk) m_le = 1;
            else begin
              for (int i = 0; i < 64; i++) wq.push_back(lat[i]);
              if (code == 3) m_lock[pg[9:5]] = 1;
            end
      2: m_lock[pg[9:5]] = 1;
      4: m_lock[pg[9:5]] = 0;
      8: if (|m_lock) m_le = 1;
      11: if (pg < 3) m_gp[pg] = 1;
      13: if (pg < 3) m_gp[pg] = 0;
      default: m_sec = 1;
    endcase
    if (code != 0 || key != KEY_VALUE)
      nq.push_back({m_sec, lfsr_s[2] | lfsr_s[1] & m_le | lfsr_s[0] & m_pe, er, m_le, m_pe,
                    m_gp, m_sec, m_lock});
    @(posedge core_clk);
    {rie, lie, pie, no_erase} <= {lfsr_s[2:0], lfsr_s[3]};
    cmd_write <= 1'b1;
    cmd_data <= {key, 6'h00, pg, 4'h0, code};
    @(posedge core_clk);
    cmd_write <= busy;
    cmd_data[31:24] <= 8'h00;
    @(posedge core_clk);
    cmd_write <= 1'b0;
    wait_rdy(1'b1);
    @(posedge core_clk) status_read <= 1'b1;
    @(posedge core_clk) status_read <= 1'b0;
    {m_pe, m_le} = 2'b00;
  endtask : run

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Cell array stand-in: finishes each operation after a random delay
  initial forever begin
    @(negedge core_clk);
    if (c_req) begin
      repeat (lfsr_s[1:0]) @(posedge core_clk);
      @(posedge core_clk) cell_done <= 1'b1;
      @(posedge core_clk) cell_done <= 1'b0;
    end
  end

  // Watcher: a completion or an error takes the oldest note
  always @(negedge core_clk) begin
    if (!reset && (rdy && !rdy_q || pe && !pe_q))
      cmp(nq.pop_front(), {dbg, irq, er_seen, le, pe, gp, sec, locks});
    if (!reset && (rdy && !rdy_q || pe && !pe_q)) er_seen = 0;
    if (c_op == CELL_ERASE_PAGE) er_seen = 1;
    if (c_wv) cmp(64 - wq.size(), c_wi);
    if (c_wv) cmp(wq.pop_front(), c_wd);
    if (c_req) cmp(pg_q, c_pg);
    if (c_op == CELL_NV_WRITE) cmp(1, rd_en);
    rdy_q = rdy;
    pe_q = pe;
  end

  initial begin
    {cmd_write, status_read, no_erase, rie, lie, pie, latch_write, hw_erase_req} = 0;
    {cell_done, m_sec, m_le, m_pe, er_seen, pe_q} = 0;
    {cmd_data, latch_addr, latch_data, m_lock, m_gp, pg_q} = 0;
    {n_mismatch, compares} = 0;
    lfsr_s = 32'hD6767D43;
    rdy_q = 1'b1;
    reset = 1'b1;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    fill;
    run(KEY_VALUE, CMD_WRITE_PAGE, 10'h005, 1'b1);
    run(KEY_VALUE, CMD_SET_LOCK, 10'h028, 1'b0);
    run(KEY_VALUE, CMD_WRITE_PAGE, 10'h021, 1'b0);
    run(KEY_VALUE, CMD_ERASE_ALL, 10'h000, 1'b0);
    fill;
    run(KEY_VALUE, CMD_WRITE_LOCK, 10'h046, 1'b1);
    run(KEY_VALUE, CMD_CLEAR_LOCK, 10'h03F, 1'b0);
    run(KEY_VALUE, CMD_CLEAR_LOCK, 10'h040, 1'b0);
    run(8'hA5, CMD_WRITE_PAGE, 10'h001, 1'b0);
    run(KEY_VALUE, CMD_SET_GP, 10'h002, 1'b0);
    for (int c = 0; c < 16; c++) run(KEY_VALUE, c[3:0], {8'h00, c[1:0]}, 1'b0);
    nq.push_back({1'b0, rie, 39'h0});
    {m_lock, m_gp, m_sec} = 0;
    @(posedge core_clk) hw_erase_req <= 1'b1;
    wait_rdy(1'b0);
    @(posedge core_clk) hw_erase_req <= 1'b0;
    wait_rdy(1'b1);
    repeat (3) @(posedge core_clk);
    cmp(0, nq.size());
    give_verdict;
  end

  initial begin
    repeat (30000) @(posedge core_clk);
    n_mismatch++;
    give_verdict;
  end
endmodule : testbench
